/* File: rtl/pin_mux.sv */
/*
 Per-pin output multiplexer: alternate function wins, else direction and data decide.
 Assumes select inputs are registered by the caller.
*/
`timescale 1ns/1ps
module pin_mux (
   port_pins_if.mux pins // Select bundle.
);
   for (genvar i = 0; i < 7; i++) begin : g_pin
      always_comb begin
         if (pins.altOe[i]) begin
            pins.padOe[i]  = 1'b1;
            pins.padOut[i] = pins.altOut[i];
         end else if (pins.altIn[i]) begin
            pins.padOe[i]  = 1'b0;
            pins.padOut[i] = 1'b0;
         end else begin
            pins.padOe[i]  = pins.dirBits[i];
            pins.padOut[i] = pins.dataBits[i];
         end
      end
   end
endmodule : pin_mux

/* File: rtl/pin_sync.sv */
/*
 Two-flip-flop synchroniser for the pad inputs.
 Assumes the pads change without relation to mclk.
*/
`timescale 1ns/1ps
module pin_sync #(
   parameter int N = 7
) (
   input  wire logic         mclk,    // System clock.
   input  wire logic         rstN,    // Synchronised reset, active low.
   input  wire logic [N-1:0] asyncIn, // Raw pad levels.
   output logic      [N-1:0] syncOut  // Pad levels in mclk domain.
);
   logic [N-1:0] stage1Reg;

   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         stage1Reg <= '0;
         syncOut   <= '0;
      end else begin
         stage1Reg <= asyncIn;
         syncOut   <= stage1Reg;
      end
   end
endmodule : pin_sync

/* File: rtl/port7_gpio_alt_function_mux.sv */
/*
 Seven-pin general I/O port with timer-V and serial-2 alternate functions, Wishbone slave.
 Assumes a single 200 MHz clock; timer and serial units sit outside and supply their signals.
*/
// What this block does
// - Direction 1 drives pin, 0 makes input.
// - Direction register write-only, resets to inputs.
// - Data bits 6..0 read/write, reset zero.
// - Output pins read back latched data.
// - Input pins read back live level.
// - Data bit 7 always reads one.
// - Nonzero timer output select claims pin 6.
// - Timer setting overrides direction on pin 6.
// - Pins 5,4 always feed timer inputs.
`timescale 1ns/1ps
module port7_gpio_alt_function_mux
   import port7_pkg::*;
(
   input  wire logic        mclk,          // 200 MHz system clock.
   input  wire logic        rstn,          // Asynchronous reset, active low.
   input  wire logic        wb_cyc_i,      // Wishbone cycle.
   input  wire logic        wb_stb_i,      // Wishbone strobe.
   input  wire logic        wb_we_i,       // Wishbone write enable.
   input  wire logic [7:0]  wb_adr_i,      // Byte address.
   input  wire logic [31:0] wb_dat_i,      // Write data.
   input  wire logic [3:0]  wb_sel_i,      // Byte selects.
   output logic      [31:0] wb_dat_o,      // Read data.
   output logic             wb_ack_o,      // Acknowledge.
   input  wire logic [6:0]  padIn,         // Pad input levels.
   output logic      [6:0]  padOut,        // Pad output levels.
   output logic      [6:0]  padOe,         // Pad output enables.
   input  wire logic        timerVOutput,  // Timer-V compare output.
   output logic             timerVClockIn, // Pin 5 to timer-V clock input.
   output logic             timerVResetIn, // Pin 4 to timer-V reset input.
   input  wire logic        serial2TxData, // Serial-2 transmit data.
   output logic             serial2RxData, // Pin 1 to serial-2 receiver.
   input  wire logic        serial2ClkOut, // Serial-2 clock to drive out.
   output logic             serial2ClkIn   // Pin 0 to serial-2 clock input.
);
   import port7_pkg::*;

   logic       rstSync1Reg;
   logic       rstNReg;
   logic [6:0] dirReg;
   logic [6:0] dataReg;
   logic [8:0] altReg;
   logic [6:0] pinSync;
   logic       ackReg;
   logic [31:0] rdataReg;
   logic [31:0] rdataNext;
   logic       busReq;
   logic [3:0] timerOs;
   logic       sckOut;
   logic       sckIn;

   port_pins_if #(.N(PIN_COUNT)) pins ();

   // Reset enters asynchronously but is released through two flops to avoid recovery hazards.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rstSync1Reg <= 1'b0;
         rstNReg     <= 1'b0;
      end else begin
         rstSync1Reg <= 1'b1;
         rstNReg     <= rstSync1Reg;
      end
   end

   pin_sync #(.N(PIN_COUNT)) u_sync (
      .mclk    (mclk),
      .rstN    (rstNReg),
      .asyncIn (padIn),
      .syncOut (pinSync)
   );

   assign busReq = wb_cyc_i && wb_stb_i && !ackReg;

   always_ff @(posedge mclk or negedge rstNReg) begin
      if (!rstNReg) begin
         dirReg <= DIR_RESET;
      end else if (busReq && wb_we_i && wb_sel_i[0] && wb_adr_i == DIR_OFFSET) begin
         dirReg <= wb_dat_i[6:0];
      end
   end

   always_ff @(posedge mclk or negedge rstNReg) begin
      if (!rstNReg) begin
         dataReg <= DATA_RESET;
      end else if (busReq && wb_we_i && wb_sel_i[0] && wb_adr_i == DATA_OFFSET) begin
         dataReg <= wb_dat_i[6:0];
      end
   end

   always_ff @(posedge mclk or negedge rstNReg) begin
      if (!rstNReg) begin
         altReg <= ALT_RESET;
      end else if (busReq && wb_we_i && wb_adr_i == ALT_OFFSET) begin
         if (wb_sel_i[0]) begin
            altReg[7:0] <= wb_dat_i[7:0];
         end
         if (wb_sel_i[1]) begin
            altReg[8] <= wb_dat_i[8];
         end
      end
   end

   // Direction register is write-only, so its offset reads zero.
   always_comb begin
      rdataNext = UNMAPPED_VALUE;
      case (wb_adr_i)
         DATA_OFFSET: begin
            rdataNext[7]   = DATA_TOP_VALUE;
            rdataNext[6:0] = (dirReg & dataReg) | (~dirReg & pinSync);
         end
         ALT_OFFSET: begin
            rdataNext[8:0] = altReg;
         end
         PINS_OFFSET: begin
            rdataNext[6:0] = pinSync;
         end
         default: begin
            rdataNext = UNMAPPED_VALUE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rstNReg) begin
      if (!rstNReg) begin
         ackReg   <= 1'b0;
         rdataReg <= 32'h00000000;
      end else begin
         ackReg   <= busReq;
         rdataReg <= (busReq && !wb_we_i) ? rdataNext : 32'h00000000;
      end
   end

   assign wb_ack_o = ackReg;
   assign wb_dat_o = rdataReg;

   assign timerOs = altReg[ALT_OS_LSB +: 4];
   // Clock-source high selects external clock in; with it clear, clock-source low or synchronous mode drives it out.
   assign sckIn   = altReg[ALT_CLOCK_SOURCE_BIT_HIGH_BIT];
   assign sckOut  = !altReg[ALT_CLOCK_SOURCE_BIT_HIGH_BIT] && (altReg[ALT_CLOCK_SOURCE_BIT_LOW_BIT] || altReg[ALT_SYNC_BIT]);

   always_comb begin
      pins.dirBits  = dirReg;
      pins.dataBits = dataReg;
      pins.altOe    = '0;
      pins.altOut   = '0;
      pins.altIn    = '0;
      pins.altOe[TMO_PIN]  = (timerOs != TMO_OFF);
      pins.altOut[TMO_PIN] = timerVOutput;
      pins.altOe[TXD_PIN]  = altReg[ALT_TXSEL_BIT];
      pins.altOut[TXD_PIN] = serial2TxData;
      pins.altIn[RXD_PIN]  = altReg[ALT_RE_BIT];
      pins.altOe[SCK_PIN]  = sckOut;
      pins.altOut[SCK_PIN] = serial2ClkOut;
      pins.altIn[SCK_PIN]  = sckIn;
   end

   pin_mux u_mux (
      .pins (pins)
   );

   assign padOut = pins.padOut;
   assign padOe  = pins.padOe;

   // Timer inputs are wired regardless of pin configuration.
   assign timerVClockIn = pinSync[TCLK_PIN];
   assign timerVResetIn = pinSync[TRST_PIN];
   assign serial2RxData = pinSync[RXD_PIN] | ~altReg[ALT_RE_BIT];
   assign serial2ClkIn  = pinSync[SCK_PIN] & sckIn;

   // The checks below watch the pad side and the bus side of the port.
   // They are disabled while the internal reset copy is low, since the pads are all inputs then.
   // Read-back checks look one cycle after the request because the read data is registered.
   property p_gpio_pin6;
      @(posedge mclk) disable iff (!rstNReg)
      (timerOs == TMO_OFF) |->
         padOe[TMO_PIN] == dirReg[TMO_PIN];
   endproperty
   a_gpio_pin6: assert property (p_gpio_pin6)
      else $error("pin 6 enable not from direction");

   property p_pin3_drive;
      @(posedge mclk) disable iff (!rstNReg)
      padOe[3] == dirReg[3] &&
         (dirReg[3] -> padOut[3] == dataReg[3]);
   endproperty
   a_pin3_drive: assert property (p_pin3_drive)
      else $error("pin 3 drive wrong");

   property p_tmo_claim;
      @(posedge mclk) disable iff (!rstNReg)
      (timerOs != TMO_OFF) |->
         padOe[TMO_PIN] && padOut[TMO_PIN] == timerVOutput;
   endproperty
   a_tmo_claim: assert property (p_tmo_claim)
      else $error("timer output not on pin 6");

   property p_tmo_over_dir;
      @(posedge mclk) disable iff (!rstNReg)
      (timerOs != TMO_OFF && !dirReg[TMO_PIN]) |->
         padOe[TMO_PIN];
   endproperty
   a_tmo_over_dir: assert property (p_tmo_over_dir)
      else $error("direction overrode timer on pin 6");

   property p_data_top;
      @(posedge mclk) disable iff (!rstNReg)
      (busReq && !wb_we_i && wb_adr_i == DATA_OFFSET) |=>
         wb_ack_o && wb_dat_o[7];
   endproperty
   a_data_top: assert property (p_data_top)
      else $error("data bit 7 not one");

   property p_read_mix;
      @(posedge mclk) disable iff (!rstNReg)
      (busReq && !wb_we_i && wb_adr_i == DATA_OFFSET) |=>
         wb_dat_o[6:0] == (($past(dirReg) & $past(dataReg)) | (~$past(dirReg) & $past(pinSync)));
   endproperty
   a_read_mix: assert property (p_read_mix)
      else $error("data readback mismatch");

   property p_read_input;
      @(posedge mclk) disable iff (!rstNReg)
      (busReq && !wb_we_i && wb_adr_i == DATA_OFFSET && dirReg == 7'h00) |=>
         wb_dat_o[6:0] == $past(pinSync);
   endproperty
   a_read_input: assert property (p_read_input)
      else $error("input pins not read live");

   property p_data_write;
      @(posedge mclk) disable iff (!rstNReg)
      (busReq && wb_we_i && wb_sel_i[0] && wb_adr_i == DATA_OFFSET) |=>
         dataReg == $past(wb_dat_i[6:0]);
   endproperty
   a_data_write: assert property (p_data_write)
      else $error("data write lost");

   property p_dir_write;
      @(posedge mclk) disable iff (!rstNReg)
      (busReq && wb_we_i && wb_sel_i[0] && wb_adr_i == DIR_OFFSET) |=>
         dirReg == $past(wb_dat_i[6:0]);
   endproperty
   a_dir_write: assert property (p_dir_write)
      else $error("direction write lost");

   property p_dir_read;
      @(posedge mclk) disable iff (!rstNReg)
      (busReq && !wb_we_i && wb_adr_i == DIR_OFFSET) |=>
         wb_ack_o && wb_dat_o == 32'h00000000;
   endproperty
   a_dir_read: assert property (p_dir_read)
      else $error("direction read not zero");

   property p_timer_in;
      @(posedge mclk) disable iff (!rstNReg)
      timerVClockIn == pinSync[TCLK_PIN] &&
         timerVResetIn == pinSync[TRST_PIN];
   endproperty
   a_timer_in: assert property (p_timer_in)
      else $error("timer inputs not wired");

   property p_timer_pins_gpio;
      @(posedge mclk) disable iff (!rstNReg)
      padOe[TCLK_PIN] == dirReg[TCLK_PIN] && padOe[TRST_PIN] == dirReg[TRST_PIN] &&
         (dirReg[TCLK_PIN] -> padOut[TCLK_PIN] == dataReg[TCLK_PIN]);
   endproperty
   a_timer_pins_gpio: assert property (p_timer_pins_gpio)
      else $error("timer input pins lost general function");

   property p_txd;
      @(posedge mclk) disable iff (!rstNReg)
      altReg[ALT_TXSEL_BIT] |->
         padOe[TXD_PIN] && padOut[TXD_PIN] == serial2TxData;
   endproperty
   a_txd: assert property (p_txd)
      else $error("transmit not on pin 2");

   property p_rxd_in;
      @(posedge mclk) disable iff (!rstNReg)
      altReg[ALT_RE_BIT] |->
         !padOe[RXD_PIN] && serial2RxData == pinSync[RXD_PIN];
   endproperty
   a_rxd_in: assert property (p_rxd_in)
      else $error("receive pin driven or not routed");

   property p_rx_idle;
      @(posedge mclk) disable iff (!rstNReg)
      !altReg[ALT_RE_BIT] |->
         serial2RxData;
   endproperty
   a_rx_idle: assert property (p_rx_idle)
      else $error("receiver not idle while disabled");

   property p_sck_in;
      @(posedge mclk) disable iff (!rstNReg)
      altReg[ALT_CLOCK_SOURCE_BIT_HIGH_BIT] |->
         !padOe[SCK_PIN] && serial2ClkIn == pinSync[SCK_PIN];
   endproperty
   a_sck_in: assert property (p_sck_in)
      else $error("clock input pin driven");

   property p_sck_out;
      @(posedge mclk) disable iff (!rstNReg)
      (!altReg[ALT_CLOCK_SOURCE_BIT_HIGH_BIT] && (altReg[ALT_CLOCK_SOURCE_BIT_LOW_BIT] || altReg[ALT_SYNC_BIT])) |->
         padOe[SCK_PIN] && padOut[SCK_PIN] == serial2ClkOut && !serial2ClkIn;
   endproperty
   a_sck_out: assert property (p_sck_out)
      else $error("clock output not on pin 0");

   property p_ack_timing;
      @(posedge mclk) disable iff (!rstNReg)
      busReq |=>
         wb_ack_o;
   endproperty
   a_ack_timing: assert property (p_ack_timing)
      else $error("request not acknowledged next cycle");

   property p_ack_pulse;
      @(posedge mclk) disable iff (!rstNReg)
      wb_ack_o |=>
         !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("acknowledge longer than one cycle");

   property p_dat_idle;
      @(posedge mclk) disable iff (!rstNReg)
      !wb_ack_o |->
         wb_dat_o == 32'h00000000;
   endproperty
   a_dat_idle: assert property (p_dat_idle)
      else $error("read data not zero outside acknowledge");

endmodule : port7_gpio_alt_function_mux

/* File: rtl/port7_pkg.sv */
/*
 Shared constants for the seven-pin general I/O port with timer and serial alternate functions.
 Assumes a 32-bit classic Wishbone register bus with word-aligned registers.
*/
package port7_pkg;
   localparam int          PIN_COUNT      = 7;
   localparam int          REG_WIDTH      = 8;
   localparam logic [7:0]  DIR_OFFSET     = 8'h00;
   localparam logic [7:0]  DATA_OFFSET    = 8'h04;
   localparam logic [7:0]  ALT_OFFSET     = 8'h08;
   localparam logic [7:0]  PINS_OFFSET    = 8'h0C;
   localparam logic [6:0]  DIR_RESET      = 7'h00;
   localparam logic [6:0]  DATA_RESET     = 7'h00;
   localparam logic        DATA_TOP_VALUE = 1'h1;
   localparam int          TMO_PIN        = 6;
   localparam int          TCLK_PIN       = 5;
   localparam int          TRST_PIN       = 4;
   localparam int          TXD_PIN        = 2;
   localparam int          RXD_PIN        = 1;
   localparam int          SCK_PIN        = 0;
   localparam logic [3:0]  TMO_OFF        = 4'h0;
   localparam int          ALT_OS_LSB     = 0;
   localparam int          ALT_TXSEL_BIT  = 4;
   localparam int          ALT_RE_BIT     = 5;
   localparam int          ALT_CLOCK_SOURCE_BIT_LOW_BIT   = 6;
   localparam int          ALT_CLOCK_SOURCE_BIT_HIGH_BIT   = 7;
   localparam int          ALT_SYNC_BIT   = 8;
   localparam logic [8:0]  ALT_RESET      = 9'h000;
   localparam logic [31:0] UNMAPPED_VALUE = 32'h00000000;
endpackage : port7_pkg

/* File: rtl/port_pins_if.sv */
/*
 Bundle carrying the per-pin function selects from the register side to the pin multiplexer.
 Assumes both ends share one clock domain.
*/
`timescale 1ns/1ps
interface port_pins_if #(parameter int N = 7);
   logic [N-1:0] dirBits;   // Direction bits, 1 means output.
   logic [N-1:0] dataBits;  // Latched output data.
   logic [N-1:0] altOe;     // Alternate function owns the pin.
   logic [N-1:0] altOut;    // Alternate function output level.
   logic [N-1:0] altIn;     // Pin is an alternate-function input.
   logic [N-1:0] padOut;    // Level driven to the pad.
   logic [N-1:0] padOe;     // Pad drive enable.
   modport regs (output dirBits, dataBits, altOe, altOut, altIn, input padOut, padOe);
   modport mux  (input dirBits, dataBits, altOe, altOut, altIn, output padOut, padOe);
endinterface : port_pins_if

/* File: verif/pad_model.sv */
/*
 Board side of the seven port pins: resolves each pin from the device drive and the board level.
 Assumes the bench sets the level that the board applies wherever the device lets go.
*/
`timescale 1ns/1ps
module pad_model (
   input  wire logic [6:0] padOut, // Device pad levels.
   input  wire logic [6:0] padOe,  // Device drive enables.
   input  wire logic [6:0] board,  // Board levels.
   output logic      [6:0] padIn   // Resolved pin levels.
);
   // A driven pin shows the device level, so read-back of outputs sees the latch, not the board.
   always_comb begin
      for (int i = 0; i < 7; i++) begin
         padIn[i] = padOe[i] ? padOut[i] : board[i];
      end
   end
endmodule : pad_model

/* File: verif/port7_gpio_alt_function_mux_tb.sv */
/*
 Self-checking bench for the seven-pin port: register access, direction, read-back and alternates.
 Assumes the pad model and a Wishbone slave that answers one cycle after taking a request.
*/
`timescale 1ns/1ps
module port7_gpio_alt_function_mux_tb;
   import port7_pkg::*;
   logic        mclk = 0, rstn = 0, cyc = 0, stb = 0, we = 0, tmo = 0, txd = 0, sck = 0;
   logic [7:0]  adr = 8'h00, r = 8'h2C;
   logic [31:0] wdat = 32'h0, rdat;
   logic [6:0]  board = 7'h00, padIn, padOut, padOe, d, v;
   logic        ack, tclk, trst, rxd, sckIn;
   logic [31:0] expQ[$];
   logic [8:0]  alts[7] = '{9'h005, 9'h010, 9'h020, 9'h080, 9'h040, 9'h100, 9'h0C0};
   logic [6:0]  oes[7] = '{7'h42, 7'h06, 7'h00, 7'h02, 7'h03, 7'h03, 7'h02};
   int          n_errors = 0, checks = 0;

   always #2.5 mclk = ~mclk;

   port7_gpio_alt_function_mux i_port7_gpio_alt_function_mux (
      .mclk(mclk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_dat_o(rdat), .wb_ack_o(ack), .padIn(padIn),
      .padOut(padOut), .padOe(padOe), .timerVOutput(tmo), .timerVClockIn(tclk),
      .timerVResetIn(trst), .serial2TxData(txd), .serial2RxData(rxd), .serial2ClkOut(sck),
      .serial2ClkIn(sckIn));
   pad_model i_pad_model (.padOut(padOut), .padOe(padOe), .board(board), .padIn(padIn));

   function automatic logic [7:0] nxt(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : nxt

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk

   task automatic summarize;
      $display("checks %0d, errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : summarize

   // Holds the request until ack is sampled, then releases; the next call adds the idle edge.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dat);
      int n;
      @(posedge mclk);
      {cyc, stb, we} <= {2'b11, w};
      adr <= a;
      wdat <= dat;
      for (n = 0; n < 20 && ack !== 1'b1; n++) begin
         @(posedge mclk);
      end
      if (ack !== 1'b1) begin
         n_errors++;
         summarize();
      end
      {cyc, stb} <= 2'b00;
   endtask : bus

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      expQ.push_back(exp);
      bus(1'b0, a, 32'h0);
   endtask : rd

   always @(posedge mclk) begin
      if (ack === 1'b1 && we === 1'b0) begin
         if (expQ.size() == 0) chk("unrequested read", 32'h0, 32'h1);
         else chk("read data", expQ.pop_front(), rdat);
      end
   end

   initial begin
      repeat (3) @(posedge mclk);
      rstn <= 1'b1;
      repeat (3) @(posedge mclk);
      chk("padOe", 32'h0, padOe);
      rd(DATA_OFFSET, 32'h80);
      rd(DIR_OFFSET, 32'h0);
      rd(8'h10, UNMAPPED_VALUE);
      $display("reset test done");
      for (int k = 0; k < 8; k++) begin
         r = nxt(r);
         d = r[6:0];
         r = nxt(r);
         v = r[6:0];
         r = nxt(r);
         board <= r[6:0];
         bus(1'b1, DIR_OFFSET, {25'h0, d});
         bus(1'b1, DATA_OFFSET, {25'h0, v});
         repeat (4) @(posedge mclk);
         chk("padOe", d, padOe);
         chk("padOut", v & d, padOut & d);
         chk("timer clock", padIn[5], tclk);
         chk("timer reset", padIn[4], trst);
         rd(DATA_OFFSET, {24'h0, 1'b1, (v & d) | (board & ~d)});
         rd(PINS_OFFSET, {25'h0, (v & d) | (board & ~d)});
      end
      $display("direction test done");
      tmo <= 1'b1;
      txd <= 1'b1;
      sck <= 1'b1;
      board <= 7'h55;
      bus(1'b1, DIR_OFFSET, 32'h2);
      bus(1'b1, DATA_OFFSET, 32'h0);
      for (int k = 0; k < 7; k++) begin
         bus(1'b1, ALT_OFFSET, {23'h0, alts[k]});
         repeat (4) @(posedge mclk);
         chk("padOe", oes[k], padOe);
         chk("alternate level", oes[k] & 7'h45, padOut & padOe & 7'h45);
         chk("receive data", alts[k][5] ? board[1] : 1'b1, rxd);
         chk("serial clock in", alts[k][7] ? board[0] : 1'b0, sckIn);
         rd(ALT_OFFSET, {23'h0, alts[k]});
      end
      $display("alternate function test done");
      summarize();
   end
endmodule : port7_gpio_alt_function_mux_tb
